/* File: rtl/pcki_pkg.sv */
package pcki_pkg;
    localparam int CNT_W = 16;
    localparam int KILL_W = 8;
    localparam int DEAD_W = 9;
    localparam logic [7:0] KILL_TIME_LO = 8'h01;
    localparam logic [7:0] KILL_TIME_HI = 8'hff;
    localparam logic [7:0] KILL_TIME_RESET = 8'h01;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int FILL_W = 3;
    localparam logic [2:0] FIFO_FULL = 3'h4;
    // capture qualification
    localparam logic [1:0] CAP_NONE = 2'h0;
    localparam logic [1:0] CAP_RISE = 2'h1;
    localparam logic [1:0] CAP_FALL = 2'h2;
    localparam logic [1:0] CAP_EITHER = 2'h3;
    // interrupt source positions in status and mask
    localparam int NUM_SRC = 4;
    localparam int SRC_TC = 0;
    localparam int SRC_CMP1 = 1;
    localparam int SRC_CMP2 = 2;
    localparam int SRC_KILL = 3;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] MASK_SOFT_ONLY = 4'h3;
    // dead band build options, one value each so they exclude each other
    localparam logic [1:0] DB_NONE = 2'h0;
    localparam logic [1:0] DB_SHORT = 2'h1;
    localparam logic [1:0] DB_LONG = 2'h2;
    localparam logic [8:0] DB_MIN = 9'h002;
    localparam logic [8:0] DB_SHORT_MAX = 9'h004;
    localparam logic [8:0] DB_LONG_MAX = 9'h100;
    // routed clock runs at most at half its source
    localparam int ROUTED_DIV = 2;
    localparam int DIV_W = 4;
    typedef enum logic [1:0] {KS_RUN = 2'b01, KS_KILL = 2'b10} pcki_kill_state_t;
endpackage : pcki_pkg

/* File: rtl/pcki_link_if.sv */
`timescale 1ns/1ns
interface pcki_link_if;
    logic pwmClkEn;
    logic capture;
    logic kill;
    logic [pcki_pkg::CNT_W-1:0] counter;
    logic termCount;
    logic cmp1;
    logic cmp2;
    logic outDisable;
    logic irq;
    modport dev (input pwmClkEn, input capture, input kill, input counter, input termCount,
                 input cmp1, input cmp2, output outDisable, output irq);
    modport far (output pwmClkEn, output capture, output kill, output counter, output termCount,
                 output cmp1, output cmp2, input outDisable, input irq);
endinterface : pcki_link_if

/* File: rtl/pcki_kill_filter.sv */
`timescale 1ns/1ns
module pcki_kill_filter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tickEn,
    input wire logic killIn,
    input wire logic killMinTimeSelected,
    input wire logic [7:0] killTime,
    output logic disableOut,
    output logic killEvent
);
    pcki_pkg::pcki_kill_state_t state, next_state;
    logic [7:0] count, next_count;
    logic killPrev, next_killPrev;
    logic next_disableOut, next_killEvent;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_killPrev = killPrev;
        next_killEvent = 1'b0;
        if (tickEn)
        begin
            next_killPrev = killIn;
            case (state)
                pcki_pkg::KS_RUN:
                begin
                    if (killIn)
                    begin
                        next_state = pcki_pkg::KS_KILL;
                        next_count = 8'h01;
                        // without the minimum-time mode a kill counts at once
                        next_killEvent = !killMinTimeSelected || (killTime == 8'h01);
                    end
                end
                pcki_pkg::KS_KILL:
                begin
                    if (killIn && !killPrev)
                        next_count = 8'h01;
                    else if (count != pcki_pkg::KILL_TIME_HI)
                        next_count = count + 8'h01;
                    // valid only once the kill has stood the full time
                    if (killMinTimeSelected && killIn && killPrev && (count + 8'h01 == killTime))
                        next_killEvent = 1'b1;
                    if (!killIn && (!killMinTimeSelected || count >= killTime))
                        next_state = pcki_pkg::KS_RUN;
                end
                default:
                    next_state = pcki_pkg::KS_RUN;
            endcase
        end
        next_disableOut = (next_state == pcki_pkg::KS_KILL);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= pcki_pkg::KS_RUN;
            count <= 8'h00;
            killPrev <= 1'b0;
            disableOut <= 1'b0;
            killEvent <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            killPrev <= next_killPrev;
            disableOut <= next_disableOut;
            killEvent <= next_killEvent;
        end
    end
endmodule : pcki_kill_filter

/* File: rtl/pcki_device.sv */
`timescale 1ns/1ns
module pcki_device #(
    parameter logic [1:0] CAPTURE_MODE = pcki_pkg::CAP_RISE,
    parameter bit KILL_MIN_TIME_SELECTED = 1'b1,
    parameter bit HARD_BLOCK_SELECTED = 1'b0,
    parameter bit INTERRUPTS_NONE = 1'b0,
    parameter bit STATUS_REG_PRESENT = 1'b1,
    parameter bit CONTROL_REG_PRESENT = 1'b1,
    parameter logic [1:0] DEAD_BAND_MODE = pcki_pkg::DB_NONE,
    parameter logic [3:0] INIT_MASK = pcki_pkg::MASK_RESET,
    parameter logic [7:0] INIT_KILL_TIME = pcki_pkg::KILL_TIME_RESET
)(
    input wire logic clk,
    input wire logic rstn,
    pcki_link_if.dev link,
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlKillTime,
    input wire logic [3:0] ctrlMask,
    input wire logic [8:0] ctrlDeadTime,
    input wire logic statusRead,
    input wire logic capturePop,
    input wire logic captureFlush,
    output logic [pcki_pkg::CNT_W-1:0] counterLive,
    output logic [pcki_pkg::CNT_W-1:0] captureData,
    output logic fifoNotEmpty,
    output logic [3:0] status,
    output logic [3:0] intMask,
    output logic [7:0] killTime,
    output logic [8:0] deadTime
);
    // compare 2 and kill sources exist only in the logic-array build
    localparam logic [3:0] SRC_ALLOWED = HARD_BLOCK_SELECTED ? pcki_pkg::MASK_SOFT_ONLY : 4'hf;

    logic [pcki_pkg::CNT_W-1:0] mem [pcki_pkg::FIFO_DEPTH];
    logic [pcki_pkg::CNT_W-1:0] next_mem [pcki_pkg::FIFO_DEPTH];
    logic [pcki_pkg::PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [pcki_pkg::FILL_W-1:0] fill, next_fill;
    logic [pcki_pkg::CNT_W-1:0] next_captureData;
    logic capPrev, next_capPrev, capEvent;
    logic [3:0] next_status, next_intMask, srcEvent;
    logic [7:0] next_killTime;
    logic [8:0] next_deadTime;
    logic killEvent, killDisable, irqReg, next_irq;

    pcki_kill_filter u_pcki_kill_filter (
        .clk(clk),
        .rstn(rstn),
        .tickEn(link.pwmClkEn),
        .killIn(link.kill),
        .killMinTimeSelected(KILL_MIN_TIME_SELECTED),
        .killTime(killTime),
        .disableOut(killDisable),
        .killEvent(killEvent)
    );
    assign link.outDisable = killDisable;
    assign link.irq = irqReg;

    // capture edge qualification
    always_comb
    begin
        next_capPrev = link.pwmClkEn ? link.capture : capPrev;
        capEvent = 1'b0;
        if (link.pwmClkEn)
        begin
            case (CAPTURE_MODE)
                pcki_pkg::CAP_RISE: capEvent = link.capture && !capPrev;
                pcki_pkg::CAP_FALL: capEvent = !link.capture && capPrev;
                pcki_pkg::CAP_EITHER: capEvent = link.capture != capPrev;
                pcki_pkg::CAP_NONE: capEvent = 1'b0;
                default: capEvent = 1'b0;
            endcase
        end
    end

    // capture FIFO; a flush in the same cycle as a capture keeps the capture
    always_comb
    begin
        next_mem = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_fill = fill;
        if (captureFlush)
        begin
            next_rdPtr = wrPtr;
            next_fill = 3'h0;
        end
        else if (capturePop && fill != 3'h0)
        begin
            next_rdPtr = rdPtr + 2'h1;
            next_fill = fill - 3'h1;
        end
        // a full FIFO drops the new capture rather than overwrite old data
        if (capEvent && next_fill != pcki_pkg::FIFO_FULL)
        begin
            next_mem[wrPtr] = link.counter;
            next_wrPtr = wrPtr + 2'h1;
            next_fill = next_fill + 3'h1;
        end
        next_captureData = (next_fill == 3'h0) ? '0 : next_mem[next_rdPtr];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int k = 0; k < pcki_pkg::FIFO_DEPTH; k++)
                mem[k] <= '0;
            wrPtr <= '0;
            rdPtr <= '0;
            fill <= '0;
            capPrev <= 1'b0;
            captureData <= '0;
            fifoNotEmpty <= 1'b0;
            counterLive <= '0;
        end
        else
        begin
            mem <= next_mem;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fill <= next_fill;
            capPrev <= next_capPrev;
            captureData <= next_captureData;
            fifoNotEmpty <= (next_fill != 3'h0);
            counterLive <= link.counter;
        end
    end

    // control register: kill time, mask, dead time
    always_comb
    begin
        next_killTime = killTime;
        next_intMask = intMask;
        next_deadTime = deadTime;
        if (CONTROL_REG_PRESENT && ctrlWrite)
        begin
            // zero is outside the legal range and would let a kill qualify only once the count saturates at 8'hff
            next_killTime = (ctrlKillTime < pcki_pkg::KILL_TIME_LO) ? pcki_pkg::KILL_TIME_LO : ctrlKillTime;
            if (!INTERRUPTS_NONE)
                next_intMask = ctrlMask & SRC_ALLOWED;
            case (DEAD_BAND_MODE)
                pcki_pkg::DB_SHORT: next_deadTime = (ctrlDeadTime < pcki_pkg::DB_MIN) ? pcki_pkg::DB_MIN :
                    (ctrlDeadTime > pcki_pkg::DB_SHORT_MAX) ? pcki_pkg::DB_SHORT_MAX : ctrlDeadTime;
                pcki_pkg::DB_LONG: next_deadTime = (ctrlDeadTime < pcki_pkg::DB_MIN) ? pcki_pkg::DB_MIN :
                    (ctrlDeadTime > pcki_pkg::DB_LONG_MAX) ? pcki_pkg::DB_LONG_MAX : ctrlDeadTime;
                default: next_deadTime = 9'h000;
            endcase
        end
    end

    // interrupt sources; hardware set wins over the clear by a status read
    assign srcEvent = {killEvent, link.cmp2, link.cmp1, link.termCount};
    genvar i;
    generate
        for (i = 0; i < pcki_pkg::NUM_SRC; i++)
        begin : g_src
            always_comb
            begin
                if (!STATUS_REG_PRESENT || !SRC_ALLOWED[i])
                    next_status[i] = 1'b0;
                else if (srcEvent[i])
                    next_status[i] = 1'b1;
                else if (statusRead)
                    next_status[i] = 1'b0;
                else
                    next_status[i] = status[i];
            end
        end
    endgenerate

    // without a status register the enabled events drive the line directly
    assign next_irq = STATUS_REG_PRESENT ? |(next_status & intMask) : |(srcEvent & intMask & SRC_ALLOWED);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            killTime <= INIT_KILL_TIME;
            intMask <= INIT_MASK & SRC_ALLOWED;
            deadTime <= 9'h000;
            status <= 4'h0;
            irqReg <= 1'b0;
        end
        else
        begin
            killTime <= next_killTime;
            intMask <= next_intMask;
            deadTime <= next_deadTime;
            status <= next_status;
            irqReg <= next_irq;
        end
    end
endmodule : pcki_device

/* File: rtl/pcki_far_end.sv */
`timescale 1ns/1ns
module pcki_far_end #(
    parameter bit HARD_BLOCK_SELECTED = 1'b0,
    parameter logic [3:0] ROUTED_DIVIDE = 4'h2
)(
    input wire logic clk,
    input wire logic rstn,
    pcki_link_if.far link,
    input wire logic captureIn,
    input wire logic killIn,
    input wire logic [pcki_pkg::CNT_W-1:0] counterIn,
    input wire logic termCountIn,
    input wire logic cmp1In,
    input wire logic cmp2In,
    output logic pwmOff,
    output logic irqOut
);
    // a divide below two would break the half-rate limit on routed clocks
    localparam logic [3:0] DIV = (ROUTED_DIVIDE < 4'(pcki_pkg::ROUTED_DIV)) ? 4'(pcki_pkg::ROUTED_DIV) : ROUTED_DIVIDE;
    logic [pcki_pkg::DIV_W-1:0] div, next_div;
    logic clkEn, next_clkEn;

    always_comb
    begin
        if (HARD_BLOCK_SELECTED)
        begin
            next_div = '0;
            next_clkEn = 1'b1;
        end
        else
        begin
            next_div = (div == DIV - 4'h1) ? 4'h0 : div + 4'h1;
            next_clkEn = (div == DIV - 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div <= '0;
            clkEn <= 1'b0;
            link.capture <= 1'b0;
            link.kill <= 1'b0;
            link.counter <= '0;
            link.termCount <= 1'b0;
            link.cmp1 <= 1'b0;
            link.cmp2 <= 1'b0;
            pwmOff <= 1'b0;
            irqOut <= 1'b0;
        end
        else
        begin
            div <= next_div;
            clkEn <= next_clkEn;
            link.capture <= captureIn;
            link.kill <= killIn;
            link.counter <= counterIn;
            link.termCount <= termCountIn;
            link.cmp1 <= cmp1In;
            link.cmp2 <= cmp2In;
            pwmOff <= link.outDisable;
            irqOut <= link.irq;
        end
    end
    assign link.pwmClkEn = clkEn;
endmodule : pcki_far_end

/* File: dv/pcki_link_properties.sv */
`timescale 1ns/1ns
module pcki_link_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pwmClkEn,
    input wire logic capture,
    input wire logic kill,
    input wire logic [pcki_pkg::CNT_W-1:0] counter,
    input wire logic termCount,
    input wire logic cmp1,
    input wire logic cmp2,
    input wire logic outDisable,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    tick_single_a: assert property (pwmClkEn |=> !pwmClkEn)
        else $error("tick enable high two cycles");
    tick_period_a: assert property (pwmClkEn |-> ##2 pwmClkEn)
        else $error("tick enable not every second cycle");
    kill_entry_a: assert property (pwmClkEn && kill && !outDisable |=> outDisable)
        else $error("kill tick did not disable outputs");
    kill_hold_a: assert property (outDisable && kill |=> outDisable)
        else $error("outputs released while kill high");
    kill_release_a: assert property ($fell(outDisable) |-> $past(pwmClkEn) && !$past(kill))
        else $error("outputs released off a quiet tick");
    kill_min_a: assert property ($rose(outDisable) |-> outDisable[*2])
        else $error("kill gating shorter than one tick");
    no_spurious_a: assert property (!outDisable && !(pwmClkEn && kill) |=> !outDisable)
        else $error("outputs disabled without kill tick");
    irq_cause_a: assert property ($rose(irq) |-> $past(termCount) || $past(cmp1) || $past(cmp2) || $past(kill, 2))
        else $error("interrupt rose without a source event");

    cover property (pwmClkEn && kill && !outDisable);
    cover property ($rose(irq));
    cover property (pwmClkEn && capture);
    cover property ($fell(outDisable));
endmodule : pcki_link_properties

/* File: dv/pcki_tb_top.sv */
`timescale 1ns/1ns
module pcki_tb_top;
    logic clk, rstn, captureIn, killIn, termCountIn, cmp1In, cmp2In, pwmOff, irqOut;
    logic [pcki_pkg::CNT_W-1:0] counterIn, counterLive, captureData;
    logic ctrlWrite, statusRead, capturePop, captureFlush, fifoNotEmpty;
    logic [7:0] ctrlKillTime;
    logic [7:0] killTime;
    logic [3:0] ctrlMask;
    logic [3:0] status;
    logic [3:0] intMask;
    logic [8:0] ctrlDeadTime;
    logic [8:0] deadTime;
    int fails = 0;
    int nTests = 0;
    int cycles = 0;

    pcki_link_if link ();
    pcki_device #(.DEAD_BAND_MODE(pcki_pkg::DB_LONG)) u_pcki_device (.clk(clk), .rstn(rstn), .link(link),
        .ctrlWrite(ctrlWrite), .ctrlKillTime(ctrlKillTime), .ctrlMask(ctrlMask), .ctrlDeadTime(ctrlDeadTime),
        .statusRead(statusRead), .capturePop(capturePop), .captureFlush(captureFlush), .counterLive(counterLive),
        .captureData(captureData), .fifoNotEmpty(fifoNotEmpty), .status(status), .intMask(intMask),
        .killTime(killTime), .deadTime(deadTime));
    pcki_far_end u_pcki_far_end (.clk(clk), .rstn(rstn), .link(link), .captureIn(captureIn), .killIn(killIn),
        .counterIn(counterIn), .termCountIn(termCountIn), .cmp1In(cmp1In), .cmp2In(cmp2In), .pwmOff(pwmOff),
        .irqOut(irqOut));
    pcki_link_properties u_pcki_link_properties (.clk(clk), .rstn(rstn), .pwmClkEn(link.pwmClkEn),
        .capture(link.capture), .kill(link.kill), .counter(link.counter), .termCount(link.termCount),
        .cmp1(link.cmp1), .cmp2(link.cmp2), .outDisable(link.outDisable), .irq(link.irq));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nTests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : printVerdict

    task automatic wr(input logic [7:0] kt, input logic [3:0] mask, input logic [8:0] dt);
        ctrlKillTime = kt;
        ctrlMask = mask;
        ctrlDeadTime = dt;
        ctrlWrite = 1'b1;
        step(1);
        ctrlWrite = 1'b0;
        step(1);
    endtask : wr

    task automatic clearStatus();
        statusRead = 1'b1;
        step(1);
        statusRead = 1'b0;
        step(1);
    endtask : clearStatus

    // counter changes before the falling edge so a wrongly taken fall shows a foreign value
    task automatic capOne(input logic [15:0] v);
        counterIn = v;
        step(1);
        captureIn = 1'b1;
        step(6);
        counterIn = 16'hbeef;
        step(1);
        captureIn = 1'b0;
        step(6);
    endtask : capOne

    task automatic testReset();
        chk("killTime", 16'h0001, 16'(killTime));
        chk("intMask", 16'h0000, 16'(intMask));
        chk("status", 16'h0000, 16'(status));
        chk("fifoNotEmpty", 16'h0000, 16'(fifoNotEmpty));
    endtask : testReset

    task automatic testCtrl();
        wr(8'h00, 4'h0, 9'h001);
        chk("killTime", 16'h0001, 16'(killTime));
        chk("deadTime", 16'h0002, 16'(deadTime));
        wr(8'hff, 4'h0, 9'h1ff);
        chk("killTime", 16'h00ff, 16'(killTime));
        chk("deadTime", 16'h0100, 16'(deadTime));
    endtask : testCtrl

    task automatic testCapture();
        for (int i = 0; i < 5; i++)
            capOne(16'h1000 + 16'(i));
        // pop held high across all four reads so the strobe is never rewritten in one time step
        capturePop = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            chk("captureData", 16'h1000 + 16'(i), captureData);
            step(1);
        end
        capturePop = 1'b0;
        chk("fifoNotEmpty", 16'h0000, 16'(fifoNotEmpty));
        chk("captureData", 16'h0000, captureData);
        capOne(16'h2222);
        capOne(16'h3333);
        chk("fifoNotEmpty", 16'h0001, 16'(fifoNotEmpty));
        captureFlush = 1'b1;
        step(1);
        captureFlush = 1'b0;
        step(1);
        chk("fifoNotEmpty", 16'h0000, 16'(fifoNotEmpty));
        counterIn = 16'ha5c3;
        step(3);
        chk("counterLive", 16'ha5c3, counterLive);
    endtask : testCapture

    task automatic testKillShort();
        wr(8'h06, 4'hf, 9'h002);
        killIn = 1'b1;
        step(4);
        killIn = 1'b0;
        step(6);
        chk("pwmOff", 16'h0001, 16'(pwmOff));
        step(20);
        chk("pwmOff", 16'h0000, 16'(pwmOff));
        chk("status", 16'h0000, 16'(status));
    endtask : testKillShort

    task automatic testKillLong();
        wr(8'h03, 4'hf, 9'h002);
        killIn = 1'b1;
        step(20);
        chk("status", 16'h0008, 16'(status));
        chk("irqOut", 16'h0001, 16'(irqOut));
        killIn = 1'b0;
        step(20);
        chk("pwmOff", 16'h0000, 16'(pwmOff));
        wr(8'h03, 4'h0, 9'h002);
        step(2);
        chk("irqOut", 16'h0000, 16'(irqOut));
        clearStatus();
        chk("status", 16'h0000, 16'(status));
    endtask : testKillLong

    task automatic testEvents();
        wr(8'h03, 4'h1, 9'h002);
        termCountIn = 1'b1;
        step(1);
        termCountIn = 1'b0;
        cmp1In = 1'b1;
        step(1);
        cmp1In = 1'b0;
        cmp2In = 1'b1;
        step(1);
        cmp2In = 1'b0;
        step(4);
        chk("status", 16'h0007, 16'(status));
        chk("irqOut", 16'h0001, 16'(irqOut));
    endtask : testEvents

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fails++;
            printVerdict();
        end
    end

    initial
    begin
        rstn = 1'b0;
        {captureIn, killIn, termCountIn, cmp1In, cmp2In} = 5'h00;
        {ctrlWrite, statusRead, capturePop, captureFlush} = 4'h0;
        counterIn = 16'h0000;
        ctrlKillTime = 8'h00;
        ctrlMask = 4'h0;
        ctrlDeadTime = 9'h000;
        step(5);
        rstn = 1'b1;
        step(1);
        testReset();
        testCtrl();
        testCapture();
        testKillShort();
        testKillLong();
        testEvents();
        printVerdict();
    end
endmodule : pcki_tb_top
